// >>> include/onoff_ctrl_pkg.sv
// package: command codes, register layouts and reset values
package onoff_ctrl_pkg;
   localparam logic [7:0] CMD_OUTPUT_CONTROL = 8'h01;
   localparam logic [7:0] CMD_TURN_ON_SOURCE = 8'h02;
   localparam logic [7:0] CMD_FAULT_CLEAR    = 8'h03;
   localparam logic [7:0] OUTPUT_CONTROL_RST = 8'h00;
   localparam logic [7:0] TURN_ON_SOURCE_RST = 8'h17;
   localparam int unsigned OC_ON_BIT      = 7;
   localparam int unsigned OC_SOFT_BIT    = 6;
   localparam int unsigned OC_MARGIN_HI   = 5;
   localparam int unsigned OC_MARGIN_LO   = 2;
   localparam int unsigned OC_HOT_HI      = 1;
   localparam int unsigned OC_HOT_LO      = 0;
   localparam int unsigned CFG_CMD_BIT    = 3;
   localparam int unsigned CFG_CP_BIT     = 2;
   localparam logic [7:0]  CFG_RO_MASK    = 8'h13;
   localparam logic [7:0]  CFG_RW_MASK    = 8'h0C;
   localparam logic [1:0]  HOT_ON_CODE    = 2'h1;
   localparam logic [3:0]  MARGIN_LO_IGN  = 4'h5;
   localparam logic [3:0]  MARGIN_LO_ACT  = 4'h6;
   localparam logic [3:0]  MARGIN_HI_IGN  = 4'h9;
   localparam logic [3:0]  MARGIN_HI_ACT  = 4'hA;
   localparam int unsigned ADDR_BITS      = 4;
   localparam int unsigned FAULT_BITS     = 8;

   typedef enum logic [1:0] {
      MARGIN_OFF,
      MARGIN_LOW,
      MARGIN_HIGH
   } margin_mode_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] code;
      logic [7:0] data;
      logic       pecClocked;
   } cmd_req_t;
endpackage

// >>> src/pmbus_output_on_off_control.sv
// output on/off, margin and fault-clear command logic
// Function
// [RULE1] slave address comes from the strap pin, one of sixteen values
// [RULE2] strap values seed registers; bus may overwrite after power-up
// [RULE3] command 01h controls output on/off and margin; resets to 00h
// [RULE4] bus on-request bit enables output only when bus-control bit set
// [RULE5] soft-shutdown bit 6 always reads zero
// [RULE6] margin field decodes off, low/high, ignore or act on faults
// [RULE7] margin low/high loads target from margin-low/high level
// [RULE8] hot field 01 asserts hot alarm on input overcurrent warning
// [RULE9] command 02h sets turn-on sources; resets to 17h
// [RULE10] config bit 4 reads fixed one
// [RULE11] config bit 3 selects whether the bus on bit is obeyed
// [RULE12] config bit 2 selects whether the enable pin is obeyed
// [RULE13] config bit 1 reads one; enable pin is active high
// [RULE14] config bit 0 reads one; off is immediate, no ramp
// [RULE15] command 03h clears all status bits and releases alert
// [RULE16] fault clear does not restart a latched-off unit
// [RULE17] persisting fault sets its bit again and re-raises alert
// [RULE18] pec is used only when the host clocked a pec byte
// [RULE19] device never stretches the bus clock
// [RULE20] with both sources enabled, output needs pin high and bus bit
`timescale 1ns/100ps
module pmbus_output_on_off_control #(
   parameter int unsigned LEVEL_W = 8
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic [onoff_ctrl_pkg::ADDR_BITS-1:0] addressStrap,
   input  wire logic                          powerUpDone,
   input  wire onoff_ctrl_pkg::cmd_req_t      cmdReq,
   input  wire logic                          enablePin,
   input  wire logic                          inputOcWarn,
   input  wire logic [onoff_ctrl_pkg::FAULT_BITS-1:0] faultPresent,
   input  wire logic [onoff_ctrl_pkg::FAULT_BITS-1:0] faultLatchOff,
   input  wire logic [LEVEL_W-1:0]            marginLowLevel,
   input  wire logic [LEVEL_W-1:0]            marginHighLevel,
   input  wire logic [LEVEL_W-1:0]            nominalLevel,
   output logic [onoff_ctrl_pkg::ADDR_BITS-1:0] slaveAddr,
   output logic [7:0]                         readData,
   output logic                               readValid,
   output logic                               pecUsed,
   output logic                               sclHoldOe,
   output logic                               outputEnable,
   output logic                               fastShutdown,
   output logic [LEVEL_W-1:0]                 targetLevel,
   output logic                               marginActOnFault,
   output logic                               hot_alarm_out,
   output logic                               alert_out,
   output logic [onoff_ctrl_pkg::FAULT_BITS-1:0] statusBits
);
   localparam int unsigned FB = onoff_ctrl_pkg::FAULT_BITS;

   // pin inputs pass two flip-flops first
   logic [1:0] enSync_r;
   logic [1:0] ocSync_r;
   logic [1:0] pudSync_r;
   logic [onoff_ctrl_pkg::ADDR_BITS-1:0] strapMeta_r;
   logic [onoff_ctrl_pkg::ADDR_BITS-1:0] strapSafe_r;
   logic [1:0]                           strapAge_r;
   logic       strapTaken_r;
   logic [7:0] outputControl_r;
   logic [7:0] outputControl_nxt;
   logic [7:0] turnOnSource_r;
   logic [7:0] turnOnSource_nxt;
   logic [FB-1:0] status_r;
   logic [FB-1:0] status_nxt;
   logic          latched_r;

   wire enSafe  = enSync_r[1];
   wire ocSafe  = ocSync_r[1];
   wire busUp   = pudSync_r[1];

   wire isWrite = cmdReq.valid && cmdReq.write;
   wire isRead  = cmdReq.valid && !cmdReq.write;
   // writes to 01h and 02h accepted only once power-up has finished; fault clear is not gated
   wire wrOc  = isWrite && busUp &&
                cmdReq.code == onoff_ctrl_pkg::CMD_OUTPUT_CONTROL; // [RULE2]
   wire wrCfg = isWrite && busUp &&
                cmdReq.code == onoff_ctrl_pkg::CMD_TURN_ON_SOURCE; // [RULE2]
   wire clrCmd = cmdReq.valid && cmdReq.write &&
                 cmdReq.code == onoff_ctrl_pkg::CMD_FAULT_CLEAR;

   function automatic onoff_ctrl_pkg::margin_mode_t
      decodeMargin(input logic [3:0] f);
      case (f)
         onoff_ctrl_pkg::MARGIN_LO_IGN,
         onoff_ctrl_pkg::MARGIN_LO_ACT:
            decodeMargin = onoff_ctrl_pkg::MARGIN_LOW;
         onoff_ctrl_pkg::MARGIN_HI_IGN,
         onoff_ctrl_pkg::MARGIN_HI_ACT:
            decodeMargin = onoff_ctrl_pkg::MARGIN_HIGH;
         default:
            decodeMargin = onoff_ctrl_pkg::MARGIN_OFF;
      endcase
   endfunction

   // soft-off bit forced to zero on write
   assign outputControl_nxt = wrOc ?
      (cmdReq.data & ~(8'h01 << onoff_ctrl_pkg::OC_SOFT_BIT)) :
      outputControl_r; // [RULE3] [RULE5]
   // read-only bits held at their fixed values
   assign turnOnSource_nxt = wrCfg ?
      ((cmdReq.data & onoff_ctrl_pkg::CFG_RW_MASK) |
       onoff_ctrl_pkg::CFG_RO_MASK) :
      turnOnSource_r; // [RULE9] [RULE10] [RULE13] [RULE14]

   wire [3:0] marginField = outputControl_r[
      onoff_ctrl_pkg::OC_MARGIN_HI:onoff_ctrl_pkg::OC_MARGIN_LO];
   wire onoff_ctrl_pkg::margin_mode_t marginMode =
      decodeMargin(marginField); // [RULE6]
   wire actCode = marginField == onoff_ctrl_pkg::MARGIN_LO_ACT ||
                  marginField == onoff_ctrl_pkg::MARGIN_HI_ACT; // [RULE6]
   wire [LEVEL_W-1:0] targetNxt =
      marginMode == onoff_ctrl_pkg::MARGIN_LOW  ? marginLowLevel :
      marginMode == onoff_ctrl_pkg::MARGIN_HIGH ? marginHighLevel :
      nominalLevel; // [RULE7]

   wire busCtl = turnOnSource_r[onoff_ctrl_pkg::CFG_CMD_BIT];
   wire pinCtl = turnOnSource_r[onoff_ctrl_pkg::CFG_CP_BIT];
   wire busOn  = outputControl_r[onoff_ctrl_pkg::OC_ON_BIT];
   // each enabled source must agree; active-high pin
   wire busOk  = !busCtl || busOn;   // [RULE4] [RULE11]
   wire pinOk  = !pinCtl || enSafe;  // [RULE12] [RULE13]
   // no source enabled keeps the output off
   wire onNxt  = (busCtl || pinCtl) && busOk && pinOk &&
                 !latched_r; // [RULE20] [RULE16]

   wire [1:0] hotField =
      outputControl_r[onoff_ctrl_pkg::OC_HOT_HI:onoff_ctrl_pkg::OC_HOT_LO];
   wire hotNxt = hotField == onoff_ctrl_pkg::HOT_ON_CODE &&
                 ocSafe; // [RULE8]

   // set wins over clear: persisting faults re-latch at once
   assign status_nxt =
      (clrCmd ? '0 : status_r) | faultPresent; // [RULE15] [RULE17]

   wire [7:0] rdMux =
      cmdReq.code == onoff_ctrl_pkg::CMD_OUTPUT_CONTROL ? outputControl_r :
      cmdReq.code == onoff_ctrl_pkg::CMD_TURN_ON_SOURCE ? turnOnSource_r :
      8'h00;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         enSync_r  <= 2'h0;
         ocSync_r  <= 2'h0;
         pudSync_r <= 2'h0;
      end else begin
         enSync_r  <= {enSync_r[0], enablePin};
         ocSync_r  <= {ocSync_r[0], inputOcWarn};
         pudSync_r <= {pudSync_r[0], powerUpDone};
      end
   end

   // strap is a pin: two flops before the address is caught
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta_r <= '0;
         strapSafe_r <= '0;
         strapAge_r  <= 2'h0;
      end else begin
         strapMeta_r <= addressStrap;
         strapSafe_r <= strapMeta_r;
         strapAge_r  <= {strapAge_r[0], 1'b1};
      end
   end

   // caught once; a later strap change needs a fresh reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slaveAddr    <= '0;
         strapTaken_r <= 1'b0;
      end else if (strapAge_r[1] && !strapTaken_r) begin
         slaveAddr    <= strapSafe_r; // [RULE1]
         strapTaken_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         outputControl_r <= onoff_ctrl_pkg::OUTPUT_CONTROL_RST; // [RULE3]
         turnOnSource_r  <= onoff_ctrl_pkg::TURN_ON_SOURCE_RST; // [RULE9]
      end else begin
         outputControl_r <= outputControl_nxt;
         turnOnSource_r  <= turnOnSource_nxt;
      end
   end

   // latch-off only cleared by reset, never by fault clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_r <= 1'b0;
      end else if (|faultLatchOff) begin
         latched_r <= 1'b1; // [RULE16]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r  <= '0;
         alert_out <= 1'b0;
      end else begin
         status_r  <= status_nxt;
         alert_out <= |status_nxt; // [RULE15] [RULE17]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         outputEnable     <= 1'b0;
         fastShutdown     <= 1'b1;
         targetLevel      <= '0;
         marginActOnFault <= 1'b0;
         hot_alarm_out    <= 1'b0;
      end else begin
         outputEnable     <= onNxt; // [RULE14]
         fastShutdown     <= 1'b1;  // [RULE14]
         targetLevel      <= targetNxt;
         marginActOnFault <= actCode;
         hot_alarm_out    <= hotNxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         readData  <= 8'h00;
         readValid <= 1'b0;
         pecUsed   <= 1'b0;
         sclHoldOe <= 1'b0;
      end else begin
         readData  <= isRead ? rdMux : 8'h00;
         readValid <= isRead;
         pecUsed   <= cmdReq.valid && cmdReq.pecClocked; // [RULE18]
         sclHoldOe <= 1'b0; // [RULE19]
      end
   end

   assign statusBits = status_r;

   // assertions
   property p_soft_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |-> !outputControl_r[onoff_ctrl_pkg::OC_SOFT_BIT];
   endproperty
   a_soft_zero: assert property (p_soft_zero) // [RULE5]
      else $error("soft-off bit not zero");

   property p_cfg_fixed;
      @(posedge ref_clk) disable iff (!rst_n)
      (turnOnSource_r & ~onoff_ctrl_pkg::CFG_RW_MASK) ==
         onoff_ctrl_pkg::CFG_RO_MASK;
   endproperty
   a_cfg_fixed: assert property (p_cfg_fixed) // [RULE10]
      else $error("fixed config bits wrong");

   property p_bus_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (busCtl && !busOn) |=> !outputEnable;
   endproperty
   a_bus_off: assert property (p_bus_off) // [RULE4]
      else $error("output on without bus request");

   property p_pin_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (pinCtl && !enSafe) |=> !outputEnable;
   endproperty
   a_pin_off: assert property (p_pin_off) // [RULE12]
      else $error("output on with enable pin low");

   property p_both_on;
      @(posedge ref_clk) disable iff (!rst_n)
      (busCtl && pinCtl && busOn && enSafe && !latched_r) |=> outputEnable;
   endproperty
   a_both_on: assert property (p_both_on) // [RULE20]
      else $error("output not on with both sources");

   property p_hot;
      @(posedge ref_clk) disable iff (!rst_n)
      hot_alarm_out |-> $past(ocSafe) &&
         $past(hotField) == onoff_ctrl_pkg::HOT_ON_CODE;
   endproperty
   a_hot: assert property (p_hot) // [RULE8]
      else $error("hot alarm without cause");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      (clrCmd && faultPresent == '0) |=> (status_r == '0 && !alert_out);
   endproperty
   a_clear: assert property (p_clear) // [RULE15]
      else $error("fault clear did not clear");

   property p_reassert;
      @(posedge ref_clk) disable iff (!rst_n)
      (clrCmd && faultPresent != '0) |=> alert_out;
   endproperty
   a_reassert: assert property (p_reassert) // [RULE17]
      else $error("persisting fault not re-raised");

   property p_latched;
      @(posedge ref_clk) disable iff (!rst_n)
      latched_r |=> !outputEnable;
   endproperty
   a_latched: assert property (p_latched) // [RULE16]
      else $error("latched unit restarted");

   property p_noscl;
      @(posedge ref_clk) disable iff (!rst_n)
      !sclHoldOe;
   endproperty
   a_noscl: assert property (p_noscl) // [RULE19]
      else $error("clock stretched");

   c_on:     cover property (@(posedge ref_clk) disable iff (!rst_n)
                             $rose(outputEnable));
   c_margin: cover property (@(posedge ref_clk) disable iff (!rst_n)
                             marginMode == onoff_ctrl_pkg::MARGIN_HIGH);
   c_clear:  cover property (@(posedge ref_clk) disable iff (!rst_n)
                             clrCmd && alert_out);
endmodule // pmbus_output_on_off_control

// >>> tb/pmbus_host_model.sv
// host-side model: issues decoded command pulses and collects answers
`timescale 1ns/100ps
module pmbus_host_model (
   input  wire logic                     ref_clk,
   input  wire logic [7:0]               readData,
   input  wire logic                     readValid,
   input  wire logic                     pecUsed,
   output onoff_ctrl_pkg::cmd_req_t      cmdReq
);
   logic [7:0] lastData;
   logic       lastPec;

   initial cmdReq = '0;

   // one-cycle request off the falling edge, then a short answer window
   task automatic xfer(input logic wr, input logic [7:0] code,
                       input logic [7:0] data, input logic pec);
      @(negedge ref_clk);
      cmdReq <= '{1'b1, wr, code, data, pec};
      lastData = 8'h00;
      lastPec = 1'b0;
      @(negedge ref_clk);
      cmdReq <= '0;
      repeat (3) begin
         if (readValid === 1'b1) lastData = readData;
         if (pecUsed === 1'b1) lastPec = 1'b1;
         @(negedge ref_clk);
      end
   endtask
endmodule // pmbus_host_model

// >>> tb/pmbus_output_on_off_control_test.sv
// self-checking bench for the output on/off command logic
`timescale 1ns/100ps
module pmbus_output_on_off_control_test;
   logic                     ref_clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic                     powerUpDone = 1'b0;
   logic                     enablePin = 1'b0;
   logic                     inputOcWarn = 1'b0;
   logic [7:0]               faultPresent = 8'h00;
   logic [7:0]               faultLatchOff = 8'h00;
   logic [7:0]               lowLvl = 8'h11;
   logic [7:0]               highLvl = 8'h22;
   logic [7:0]               nomLvl = 8'h33;
   onoff_ctrl_pkg::cmd_req_t cmdReq;
   logic [3:0]               slaveAddr;
   logic [7:0]               readData, targetLevel, statusBits;
   logic                     readValid, pecUsed, sclHoldOe, outputEnable;
   logic                     fastShutdown, marginActOnFault;
   logic                     hot_alarm_out, alert_out;
   logic [7:0]               rdv, op, cfg;
   logic                     pecv;
   logic [31:0]              seed = 32'hCDAFB463;
   logic [3:0]               strap = 4'hA;
   logic [3:0]               mcodes [6] =
      '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA};
   int                       err_total = 0;
   int                       n_tests = 0;

   always #50 ref_clk = ~ref_clk;

   pmbus_host_model i_pmbus_host_model (.ref_clk(ref_clk),
      .readData(readData), .readValid(readValid), .pecUsed(pecUsed),
      .cmdReq(cmdReq));

   pmbus_output_on_off_control i_pmbus_output_on_off_control (
      .ref_clk(ref_clk), .rst_n(rst_n), .addressStrap(strap),
      .powerUpDone(powerUpDone), .cmdReq(cmdReq), .enablePin(enablePin),
      .inputOcWarn(inputOcWarn), .faultPresent(faultPresent),
      .faultLatchOff(faultLatchOff), .marginLowLevel(lowLvl),
      .marginHighLevel(highLvl), .nominalLevel(nomLvl),
      .slaveAddr(slaveAddr), .readData(readData), .readValid(readValid),
      .pecUsed(pecUsed), .sclHoldOe(sclHoldOe),
      .outputEnable(outputEnable), .fastShutdown(fastShutdown),
      .targetLevel(targetLevel), .marginActOnFault(marginActOnFault),
      .hot_alarm_out(hot_alarm_out), .alert_out(alert_out),
      .statusBits(statusBits));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   // at least one source must be enabled, and every enabled one must agree
   function automatic logic expOe(input logic [7:0] c, input logic [7:0] o,
                                  input logic pin);
      return (c[3] | c[2]) & (!c[3] | o[7]) & (!c[2] | pin);
   endfunction

   function automatic logic [7:0] expTgt(input logic [7:0] o);
      case (o[5:2])
         4'h5, 4'h6: return lowLvl;
         4'h9, 4'hA: return highLvl;
         default:    return nomLvl;
      endcase
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic xf(input logic wr, input logic [7:0] code,
                     input logic [7:0] data, input logic pec);
      i_pmbus_host_model.xfer(wr, code, data, pec);
      rdv = i_pmbus_host_model.lastData;
      pecv = i_pmbus_host_model.lastPec;
   endtask

   task automatic tally_and_finish;
      $display("mismatches=%0d comparisons=%0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #500000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(slaveAddr, 8'h0A);
      chk(fastShutdown, 8'h01);
      chk(sclHoldOe, 8'h00);
      // writes before power-up must be dropped silently
      xf(1'b1, 8'h01, 8'h80, 1'b0);
      xf(1'b0, 8'h01, 8'h00, 1'b0);
      chk(rdv, 8'h00);
      xf(1'b0, 8'h02, 8'h00, 1'b0);
      chk(rdv, 8'h17);
      powerUpDone = 1'b1;
      repeat (3) @(negedge ref_clk);
      xf(1'b1, 8'h01, 8'hFF, 1'b0);
      xf(1'b0, 8'h01, 8'h00, 1'b0);
      chk(rdv, 8'hBF);
      xf(1'b1, 8'h02, 8'h00, 1'b0);
      xf(1'b0, 8'h02, 8'h00, 1'b0);
      chk(rdv, 8'h13);
      xf(1'b1, 8'h02, 8'hFF, 1'b0);
      xf(1'b0, 8'h02, 8'h00, 1'b0);
      chk(rdv, 8'h1F);
      xf(1'b0, 8'h55, 8'h00, 1'b1);
      chk(rdv, 8'h00);
      chk(pecv, 8'h01);
      xf(1'b0, 8'h01, 8'h00, 1'b0);
      chk(pecv, 8'h00);
      repeat (40) begin
         seed = xs(seed);
         cfg = {4'h1, seed[1:0], 2'h3};
         op = {seed[2], seed[11], mcodes[int'(seed[10:8]) % 6], seed[7:6]};
         enablePin = seed[12];
         inputOcWarn = seed[13];
         lowLvl = seed[23:16];
         highLvl = seed[31:24];
         xf(1'b1, 8'h02, cfg, 1'b0);
         xf(1'b1, 8'h01, op, 1'b0);
         xf(1'b0, 8'h01, 8'h00, 1'b0);
         chk(rdv, op & 8'hBF);
         chk(outputEnable, expOe(cfg, op, enablePin));
         chk(targetLevel, expTgt(op));
         chk(marginActOnFault, op[5:2] == 4'h6 || op[5:2] == 4'hA);
         chk(hot_alarm_out, op[1:0] == 2'h1 && inputOcWarn);
      end
      // status bits stick after the fault goes away, until cleared
      enablePin = 1'b1;
      xf(1'b1, 8'h02, 8'h04, 1'b0);
      faultPresent = 8'h05;
      repeat (3) @(negedge ref_clk);
      faultPresent = 8'h00;
      repeat (3) @(negedge ref_clk);
      chk(statusBits, 8'h05);
      chk(alert_out, 8'h01);
      xf(1'b1, 8'h03, 8'h00, 1'b0);
      chk(statusBits, 8'h00);
      chk(alert_out, 8'h00);
      faultPresent = 8'h02;
      repeat (3) @(negedge ref_clk);
      xf(1'b1, 8'h03, 8'h00, 1'b0);
      chk(statusBits, 8'h02);
      chk(alert_out, 8'h01);
      chk(outputEnable, 8'h01);
      faultLatchOff = 8'h01;
      repeat (3) @(negedge ref_clk);
      faultLatchOff = 8'h00;
      xf(1'b1, 8'h03, 8'h00, 1'b0);
      chk(outputEnable, 8'h00);
      // second reset mid-run: new strap, latch-off and registers cleared
      seed = xs(seed);
      strap = seed[3:0];
      rst_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(slaveAddr, strap);
      chk(outputEnable, 8'h01);
      xf(1'b0, 8'h01, 8'h00, 1'b0);
      chk(rdv, 8'h00);
      tally_and_finish();
   end
endmodule // pmbus_output_on_off_control_test
